// *** dual_8bit_timer_modes_tb_top.sv ***
// Self-checking bench for the timer pair
`timescale 1ns/100ps
`include "timer_pair_cfg.svh"
module dual_8bit_timer_modes_tb_top;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0;
  logic        rd_en_i = 1'b0, ext_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wr_data_i = 8'h00, rd_data_o, d;
  logic        pin_o, lirq_o, uirq_o, lmatch_o;
  logic [8:0]  high_w;
  logic [31:0] seed = 32'd49917;
  int          failures = 0, num_checks = 0, n, c, u, a, p;
  timer_pair DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .external_clock_pin_i(ext_i),
    .timer_output_pin_o(pin_o), .lower_timer_irq_o(lirq_o),
    .upper_timer_irq_o(uirq_o), .lower_match_o(lmatch_o));
  output_load load (.clk_i(clk_i), .pin_i(pin_o), .high_cnt_o(high_w));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [7:0] rnd(input int lo, input int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 8'(lo + int'(seed % 32'(span)));
  endfunction
  task automatic chk(input logic [15:0] got, input int exp);
    num_checks++;
    if (got !== 16'(exp)) begin
      failures++;
      $display("unexpected at %0t: got %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    addr_i <= ad;
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] ad);
    addr_i <= ad;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
    @(posedge clk_i);
  endtask
  // Stop, load mode, lower then upper compare, flip-flop control, run
  task automatic cfg(input logic [7:0] m, lc, uc, ff, run);
    wr(`TP_OFF_RUN, 8'h00);
    wr(`TP_OFF_MODE, m);
    wr(`TP_OFF_LOWER_CMP, lc);
    wr(`TP_OFF_UPPER_CMP, uc);
    wr(`TP_OFF_FFCR, ff);
    wr(`TP_OFF_RUN, run);
  endtask
  // Cycles between two pulses of the lower (0) or upper (1) irq
  task automatic gap(input int sel, input int lim);
    n = 0;
    do @(negedge clk_i);
    while ((sel ? uirq_o : lirq_o) !== 1'b1 && ++n < lim);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((sel ? uirq_o : lirq_o) !== 1'b1 && n < lim);
    // Second edge lets the load settle its capture of the last fall
    repeat (2) @(posedge clk_i);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    $display("unexpected at %0t: watchdog expired", $time);
    failures++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    wr(4'h9, 8'h5a);
    for (p = 0; p < 10; p++) begin
      rd(4'(p));
      chk(d, (p == 4) ? int'(`TP_FF_CTL_RESET) << `TP_FF_CTL_LSB : 0);
    end
    $display("reset test done");
    repeat (3) begin
      c = rnd(2, 38);
      u = rnd(2, 38);
      cfg(8'h05, 8'(c), 8'(u), 8'h06, 8'h03);
      gap(0, 600);
      chk(n, c);
      gap(1, 600);
      chk(n, u);
      gap(0, 600);
      chk(high_w, c);
    end
    c = rnd(2, 8);
    u = rnd(2, 8);
    cfg(8'h01, 8'(c), 8'(u), 8'h06, 8'h03);
    gap(1, 300);
    chk(n, c * u);
    $display("dual test done");
    cfg(8'h00, 8'h00, 8'h00, 8'h0f, 8'h01);
    c = rnd(3, 17);
    repeat (c) begin
      ext_i <= 1'b1;
      @(posedge clk_i);
      ext_i <= 1'b0;
      @(posedge clk_i);
    end
    rd(`TP_OFF_LOWER_CNT);
    chk(d, c);
    // Lower div4, div16, then upper div16, div256: about eight ticks each
    for (p = 0; p < 4; p++) begin
      cfg((p < 2) ? 8'(2 + p) : 8'(p << 2), 8'h00, 8'h00, 8'h0f,
          (p < 2) ? 8'h01 : 8'h02);
      repeat ((p == 3) ? 2048 : (p == 0) ? 32 : 128) @(posedge clk_i);
      rd((p < 2) ? `TP_OFF_LOWER_CNT : `TP_OFF_UPPER_CNT);
      chk(16'(d >= 8'h07 && d <= 8'h09), 1);
    end
    wr(`TP_OFF_FFCR, 8'h0a);
    wr(`TP_OFF_FFCR, 8'h00);
    rd(`TP_OFF_FFCR);
    chk(d, 1 << `TP_FF_STATE_BIT);
    chk(pin_o, 1);
    $display("clock test done");
    c = rnd(8, 26);
    cfg(8'h45, 8'(c), 8'h01, 8'h0a, 8'h03);
    gap(1, 600);
    chk(n, 256 + c);
    chk(high_w, 256 + c);
    wr(`TP_OFF_LOWER_CMP, 8'(c));
    gap(1, 600);
    chk(n, 600);
    wr(`TP_OFF_RUN, 8'h00);
    wr(`TP_OFF_UPPER_CMP, 8'h01);
    wr(`TP_OFF_RUN, 8'h03);
    gap(1, 600);
    chk(n, 256 + c);
    $display("cascade test done");
    a = rnd(4, 27);
    u = a + rnd(10, 40);
    cfg(8'h81, 8'(a), 8'(u), 8'h0a, 8'h03);
    gap(0, 600);
    chk(n, u);
    chk(high_w, u - a);
    c = rnd(2, 20);
    wr(`TP_OFF_RUN, 8'h07);
    wr(`TP_OFF_LOWER_CMP, 8'(c));
    gap(0, 600);
    chk(high_w, u - c);
    $display("pulse test done");
    for (p = 1; p < 4; p++) begin
      c = rnd(4, 50);
      u = rnd(2, 60);
      cfg(8'hc5 | 8'(p << 4), 8'(c), 8'(u), 8'h0a, 8'h03);
      gap(0, 600);
      chk(n, 32 << p);
      chk(high_w, (32 << p) - c);
      gap(1, 600);
      chk(n, u);
      wr(`TP_OFF_RUN, 8'h07);
      wr(`TP_OFF_LOWER_CMP, 8'(c + 1));
      gap(0, 600);
      chk(high_w, (32 << p) - c - 1);
    end
    $display("pwm test done");
    test_done();
  end
endmodule : dual_8bit_timer_modes_tb_top

// *** output_load.sv ***
// Load on the timer output pin, measuring its high pulses
`timescale 1ns/100ps
module output_load (
  input  wire logic       clk_i,
  input  wire logic       pin_i,
  output logic      [8:0] high_cnt_o
);
  logic [8:0] run_cnt = 9'h000;
  logic       pin_q   = 1'b0;
  initial high_cnt_o = 9'h000;
  // Width of the last completed high pulse, in clock cycles
  always @(posedge clk_i) begin
    pin_q <= pin_i;
    run_cnt <= pin_i ? run_cnt + 9'h001 : 9'h000;
    if (pin_q && !pin_i) begin
      high_cnt_o <= run_cnt;
    end
  end
endmodule : output_load

// *** timer_pair.sv ***
// Cascadable pair of 8-bit timers with output flip-flop
//
// Behaviour
// - Lower timer clock: external pin edge, or div1, div4, div16 tap.
// - Upper timer clock: lower match, or div1, div16, div256 tap.
// - Square wave: flip-flop toggles on each match of selected timer.
// - Mode 01 cascades both timers into one 16-bit interval timer.
// - In 16-bit mode upper counts lower overflow, ignoring its select.
// - Lower compare write suspends 16-bit compare until upper written.
// - 16-bit mode lower match pulses only; no clear, no lower irq.
// - Both match: clear both, upper irq, toggle if enabled.
// - Pulse mode inverts output on match with either compare register.
// - Pulse mode buffer loads lower compare on upper compare match.
// - Either polarity; control 10 presets flip-flop clear.
// - PWM on lower timer drives output; upper stays free 8-bit timer.
// - PWM resolution up to 8 bits.
// - PWM inverts on lower compare and on 2^n overflow, n 6/7/8.
// - PWM clears lower counter on 2^n overflow.
// - PWM buffer loads lower compare on 2^n overflow.
// - Mode 00 dual, 01 16-bit, 10 pulse, 11 PWM.
// - PWM period field 01, 10, 11 give 2^6, 2^7, 2^8.
`timescale 1ns/100ps
`include "timer_pair_cfg.svh"

module timer_pair #(
  parameter int ADDR_W = `TP_ADDR_W,
  parameter int DATA_W = `TP_DATA_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  input  wire logic              external_clock_pin_i,
  output logic                   timer_output_pin_o,
  output logic                   lower_timer_irq_o,
  output logic                   upper_timer_irq_o,
  output logic                   lower_match_o
);

  logic [7:0]  lower_up_counter_reg;
  logic [7:0]  upper_up_counter_reg;
  logic [7:0]  lower_compare_reg;
  logic [7:0]  upper_compare_reg;
  logic [7:0]  lower_buffer_reg;
  logic        lower_run_reg;
  logic        upper_run_bit_reg;
  logic        dbuf_en_reg;
  logic [1:0]  lower_clock_select_reg;
  logic [1:0]  upper_clock_select_field_reg;
  logic [1:0]  pwm_period_field_reg;
  logic [1:0]  mode_select_field_reg;
  logic        inv_sel_reg;
  logic        inv_en_reg;
  logic [1:0]  ff_ctl_reg;
  logic        output_flip_flop_reg;
  logic        cmp_en_reg;
  logic        ext_q_reg;
  logic        lower_irq_reg;
  logic        upper_irq_reg;
  logic        lower_match_reg;
  logic [DATA_W-1:0] rd_data_reg;

  logic tap1;
  logic tap4;
  logic tap16;
  logic tap256;
  logic ext_edge;
  logic lower_tick;
  logic upper_src;
  logic upper_tick;
  logic [7:0] lower_inc;
  logic [7:0] upper_inc;
  logic [7:0] upper_after;
  logic [7:0] pwm_top;
  logic lower_eq;
  logic upper_eq;
  logic lower_hit;
  logic m8_lower;
  logic m8_upper;
  logic m16_full;
  logic ppg_low;
  logic ppg_high;
  logic pwm_cmp;
  logic pwm_ovf;
  logic buf_load;
  logic ff_toggle;
  logic is_dual;
  logic is_casc;
  logic is_pulse;
  logic is_pwm;

  // Address decode shared by reads and writes
  function automatic logic sel_hit(input logic [ADDR_W-1:0] a,
                                   input logic [3:0]        off);
    sel_hit = (a == ADDR_W'(off));
  endfunction : sel_hit

  timer_prescaler #(
    .CNT_W (8)
  ) u_prescaler (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .prescale_tap_div1_o   (tap1),
    .prescale_tap_div4_o   (tap4),
    .prescale_tap_div16_o  (tap16),
    .prescale_tap_div256_o (tap256)
  );

  assign is_dual  = mode_select_field_reg ==
                    timer_pair_pkg::MODE_DUAL8;
  assign is_casc  = mode_select_field_reg ==
                    timer_pair_pkg::MODE_CASC16;
  assign is_pulse = mode_select_field_reg ==
                    timer_pair_pkg::MODE_PULSE;
  assign is_pwm   = mode_select_field_reg ==
                    timer_pair_pkg::MODE_PWM;

  assign ext_edge = external_clock_pin_i & ~ext_q_reg;

  // Lower clock source
  always_comb begin
    case (lower_clock_select_reg)
      2'h0:    lower_tick = ext_edge;
      2'h1:    lower_tick = tap1;
      2'h2:    lower_tick = tap4;
      2'h3:    lower_tick = tap16;
      default: lower_tick = 1'b0;
    endcase
    lower_tick = lower_tick & lower_run_reg;
  end

  assign lower_inc = lower_up_counter_reg + 8'h01;
  assign lower_eq  = lower_inc == lower_compare_reg;
  assign lower_hit = lower_tick & lower_eq;

  // Upper clock source
  always_comb begin
    case (upper_clock_select_field_reg)
      2'h0:    upper_src = lower_hit;
      2'h1:    upper_src = tap1;
      2'h2:    upper_src = tap16;
      2'h3:    upper_src = tap256;
      default: upper_src = 1'b0;
    endcase
    if (is_casc) begin
      upper_src = lower_tick &&
                  (lower_up_counter_reg == 8'hff);
    end
    upper_tick = upper_src & upper_run_bit_reg & ~is_pulse;
  end

  assign upper_inc   = upper_up_counter_reg + 8'h01;
  assign upper_eq    = upper_inc == upper_compare_reg;
  assign upper_after = upper_tick ? upper_inc : upper_up_counter_reg;

  // PWM period top
  always_comb begin
    case (pwm_period_field_reg)
      timer_pair_pkg::PWM_PER_2P6: pwm_top = `TP_PWM_TOP_2P6;
      timer_pair_pkg::PWM_PER_2P7: pwm_top = `TP_PWM_TOP_2P7;
      timer_pair_pkg::PWM_PER_2P8: pwm_top = `TP_PWM_TOP_2P8;
      default:                     pwm_top = `TP_PWM_TOP_2P8;
    endcase
  end

  assign m8_lower = is_dual & lower_hit;
  assign m8_upper = (is_dual | is_pwm) & upper_tick & upper_eq;
  assign m16_full = is_casc & cmp_en_reg & lower_hit &
                    (upper_after == upper_compare_reg);
  assign ppg_low  = is_pulse & lower_hit;
  assign ppg_high = is_pulse & lower_tick &
                    (lower_inc == upper_compare_reg);
  assign pwm_cmp  = is_pwm & lower_hit;
  assign pwm_ovf  = is_pwm & lower_tick &
                    (lower_up_counter_reg == pwm_top);
  assign buf_load = dbuf_en_reg &
                    (ppg_high | pwm_ovf);

  // Flip-flop inversion request by mode
  always_comb begin
    case (mode_select_field_reg)
      timer_pair_pkg::MODE_DUAL8:
        ff_toggle = inv_en_reg &
                    (inv_sel_reg ? m8_upper : m8_lower);
      timer_pair_pkg::MODE_CASC16:
        ff_toggle = inv_en_reg & m16_full;
      timer_pair_pkg::MODE_PULSE:
        ff_toggle = ppg_low ^ ppg_high;
      timer_pair_pkg::MODE_PWM:
        ff_toggle = pwm_cmp ^ pwm_ovf;
      default:
        ff_toggle = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= external_clock_pin_i;
    end
  end

  // Lower counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lower_up_counter_reg <= 8'h00;
    end else if (!lower_run_reg) begin
      lower_up_counter_reg <= 8'h00;
    end else if (lower_tick) begin
      if (m8_lower | m16_full | ppg_high | pwm_ovf) begin
        lower_up_counter_reg <= 8'h00;
      end else begin
        lower_up_counter_reg <= lower_inc;
      end
    end
  end

  // Upper counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      upper_up_counter_reg <= 8'h00;
    end else if (!upper_run_bit_reg) begin
      upper_up_counter_reg <= 8'h00;
    end else if (m16_full) begin
      upper_up_counter_reg <= 8'h00;
    end else if (upper_tick) begin
      if (m8_upper) begin
        upper_up_counter_reg <= 8'h00;
      end else begin
        upper_up_counter_reg <= upper_inc;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lower_run_reg                <= 1'b0;
      upper_run_bit_reg            <= 1'b0;
      dbuf_en_reg                  <= 1'b0;
      lower_clock_select_reg       <= 2'h0;
      upper_clock_select_field_reg <= 2'h0;
      pwm_period_field_reg         <= 2'h0;
      mode_select_field_reg        <= 2'h0;
      inv_sel_reg                  <= 1'b0;
      inv_en_reg                   <= 1'b0;
      ff_ctl_reg                   <= `TP_FF_CTL_RESET;
    end else if (wr_en_i) begin
      if (sel_hit(addr_i, `TP_OFF_RUN)) begin
        lower_run_reg     <= wr_data_i[`TP_RUN_LOWER_BIT];
        upper_run_bit_reg <= wr_data_i[`TP_RUN_UPPER_BIT];
        dbuf_en_reg       <= wr_data_i[`TP_RUN_DBUF_BIT];
      end
      if (sel_hit(addr_i, `TP_OFF_MODE)) begin
        lower_clock_select_reg <=
          wr_data_i[`TP_MODE_LCLK_LSB +: 2];
        upper_clock_select_field_reg <=
          wr_data_i[`TP_MODE_UCLK_LSB +: 2];
        pwm_period_field_reg  <= wr_data_i[`TP_MODE_PWM_LSB +: 2];
        mode_select_field_reg <= wr_data_i[`TP_MODE_SEL_LSB +: 2];
      end
      if (sel_hit(addr_i, `TP_OFF_FFCR)) begin
        inv_sel_reg <= wr_data_i[`TP_FF_INV_SEL_BIT];
        inv_en_reg  <= wr_data_i[`TP_FF_INV_EN_BIT];
        ff_ctl_reg  <= wr_data_i[`TP_FF_CTL_LSB +: 2];
      end
    end
  end

  // Compare registers, buffer and 16-bit compare enable
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lower_compare_reg <= `TP_CMP_RESET;
      upper_compare_reg <= `TP_CMP_RESET;
      lower_buffer_reg  <= `TP_CMP_RESET;
      cmp_en_reg        <= 1'b1;
    end else begin
      if (buf_load) begin
        lower_compare_reg <= lower_buffer_reg;
      end
      if (wr_en_i && sel_hit(addr_i, `TP_OFF_LOWER_CMP)) begin
        lower_buffer_reg <= wr_data_i;
        if (!dbuf_en_reg) begin
          lower_compare_reg <= wr_data_i;
        end
        cmp_en_reg <= 1'b0;
      end
      if (wr_en_i && sel_hit(addr_i, `TP_OFF_UPPER_CMP)) begin
        upper_compare_reg <= wr_data_i;
        cmp_en_reg        <= 1'b1;
      end
    end
  end

  // Output flip-flop; a software preset wins over a hardware toggle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      output_flip_flop_reg <= 1'b0;
    end else if (wr_en_i && sel_hit(addr_i, `TP_OFF_FFCR) &&
                 wr_data_i[`TP_FF_CTL_LSB +: 2] != `TP_FF_CTL_RESET) begin
      case (wr_data_i[`TP_FF_CTL_LSB +: 2])
        `TP_FF_CTL_INVERT: output_flip_flop_reg <= ~output_flip_flop_reg;
        `TP_FF_CTL_SET:    output_flip_flop_reg <= 1'b1;
        `TP_FF_CTL_CLEAR:  output_flip_flop_reg <= 1'b0;
        default:           output_flip_flop_reg <= output_flip_flop_reg;
      endcase
    end else if (ff_toggle) begin
      output_flip_flop_reg <= ~output_flip_flop_reg;
    end
  end

  // Event pulses
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lower_irq_reg   <= 1'b0;
      upper_irq_reg   <= 1'b0;
      lower_match_reg <= 1'b0;
    end else begin
      lower_irq_reg   <= m8_lower | ppg_high | pwm_ovf;
      upper_irq_reg   <= m8_upper | m16_full;
      lower_match_reg <= lower_hit;
    end
  end

  // Read port
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= '0;
    end else if (rd_en_i) begin
      rd_data_reg <= '0;
      if (sel_hit(addr_i, `TP_OFF_RUN)) begin
        rd_data_reg[`TP_RUN_LOWER_BIT] <= lower_run_reg;
        rd_data_reg[`TP_RUN_UPPER_BIT] <= upper_run_bit_reg;
        rd_data_reg[`TP_RUN_DBUF_BIT]  <= dbuf_en_reg;
      end
      if (sel_hit(addr_i, `TP_OFF_MODE)) begin
        rd_data_reg[7:0] <= {mode_select_field_reg,
                             pwm_period_field_reg,
                             upper_clock_select_field_reg,
                             lower_clock_select_reg};
      end
      if (sel_hit(addr_i, `TP_OFF_LOWER_CMP)) begin
        rd_data_reg[7:0] <= lower_compare_reg;
      end
      if (sel_hit(addr_i, `TP_OFF_UPPER_CMP)) begin
        rd_data_reg[7:0] <= upper_compare_reg;
      end
      if (sel_hit(addr_i, `TP_OFF_FFCR)) begin
        rd_data_reg[`TP_FF_INV_SEL_BIT]  <= inv_sel_reg;
        rd_data_reg[`TP_FF_INV_EN_BIT]   <= inv_en_reg;
        rd_data_reg[`TP_FF_CTL_LSB +: 2] <= ff_ctl_reg;
        rd_data_reg[`TP_FF_STATE_BIT]    <= output_flip_flop_reg;
      end
      if (sel_hit(addr_i, `TP_OFF_LOWER_CNT)) begin
        rd_data_reg[7:0] <= lower_up_counter_reg;
      end
      if (sel_hit(addr_i, `TP_OFF_UPPER_CNT)) begin
        rd_data_reg[7:0] <= upper_up_counter_reg;
      end
      if (sel_hit(addr_i, `TP_OFF_LOWER_BUF)) begin
        rd_data_reg[7:0] <= lower_buffer_reg;
      end
    end
  end

  assign rd_data_o          = rd_data_reg;
  assign timer_output_pin_o = output_flip_flop_reg;
  assign lower_timer_irq_o  = lower_irq_reg;
  assign upper_timer_irq_o  = upper_irq_reg;
  assign lower_match_o      = lower_match_reg;

endmodule : timer_pair

// *** timer_pair_cfg.svh ***
// Register offsets, field positions, reset values and tap counts
`ifndef TIMER_PAIR_CFG_SVH
`define TIMER_PAIR_CFG_SVH

`define TP_ADDR_W          4
`define TP_DATA_W          8

`define TP_OFF_RUN         4'h0
`define TP_OFF_MODE        4'h1
`define TP_OFF_LOWER_CMP   4'h2
`define TP_OFF_UPPER_CMP   4'h3
`define TP_OFF_FFCR        4'h4
`define TP_OFF_LOWER_CNT   4'h5
`define TP_OFF_UPPER_CNT   4'h6
`define TP_OFF_LOWER_BUF   4'h7

`define TP_RUN_LOWER_BIT   0
`define TP_RUN_UPPER_BIT   1
`define TP_RUN_DBUF_BIT    2

`define TP_MODE_LCLK_LSB   0
`define TP_MODE_UCLK_LSB   2
`define TP_MODE_PWM_LSB    4
`define TP_MODE_SEL_LSB    6

`define TP_FF_INV_SEL_BIT  0
`define TP_FF_INV_EN_BIT   1
`define TP_FF_CTL_LSB      2
`define TP_FF_STATE_BIT    4

`define TP_FF_CTL_INVERT   2'h0
`define TP_FF_CTL_SET      2'h1
`define TP_FF_CTL_CLEAR    2'h2
`define TP_FF_CTL_RESET    2'h3
`define TP_CMP_RESET       8'h00

`define TP_PWM_TOP_2P6     8'h3f
`define TP_PWM_TOP_2P7     8'h7f
`define TP_PWM_TOP_2P8     8'hff

`define TP_TAP_DIV4_MASK   8'h03
`define TP_TAP_DIV16_MASK  8'h0f
`define TP_TAP_DIV256_MASK 8'hff

`endif

// *** timer_pair_pkg.sv ***
// Types shared by the timer pair
package timer_pair_pkg;

  typedef enum logic [1:0] {
    MODE_DUAL8 = 2'h0,
    MODE_CASC16 = 2'h1,
    MODE_PULSE = 2'h2,
    MODE_PWM = 2'h3
  } timer_mode_t;

  typedef enum logic [1:0] {
    PWM_PER_NONE = 2'h0,
    PWM_PER_2P6 = 2'h1,
    PWM_PER_2P7 = 2'h2,
    PWM_PER_2P8 = 2'h3
  } pwm_period_t;

endpackage : timer_pair_pkg

// *** timer_pair_properties.sv ***
// Port checker for the timer pair, bound to its top module
`timescale 1ns/100ps
`include "timer_pair_cfg.svh"
module timer_pair_properties (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       external_clock_pin_i,
  input wire logic       timer_output_pin_o,
  input wire logic       lower_timer_irq_o,
  input wire logic       upper_timer_irq_o,
  input wire logic       lower_match_o
);
  logic [7:0] mode_reg, lcmp_reg, ucmp_reg;
  logic [2:0] run_reg;
  logic [8:0] gap_reg, per_exp;
  logic       seen_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the configuration written by software
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_reg <= 8'h00;
      lcmp_reg <= 8'h00;
      ucmp_reg <= 8'h00;
      run_reg  <= 3'h0;
    end else if (wr_en_i) begin
      case (addr_i)
        `TP_OFF_RUN:       run_reg  <= wr_data_i[2:0];
        `TP_OFF_MODE:      mode_reg <= wr_data_i;
        `TP_OFF_LOWER_CMP: lcmp_reg <= wr_data_i;
        `TP_OFF_UPPER_CMP: ucmp_reg <= wr_data_i;
        default: ;
      endcase
    end
  end
  // Cycles since the last lower irq; any write restarts the watch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wr_en_i) begin
      seen_reg <= 1'b0;
      gap_reg  <= 9'h000;
    end else if (lower_timer_irq_o) begin
      seen_reg <= 1'b1;
      gap_reg  <= 9'h001;
    end else if (gap_reg != 9'h1ff) begin
      gap_reg <= gap_reg + 9'h001;
    end
  end
  always_comb begin
    case (mode_reg[7:6])
      2'h0: per_exp = (lcmp_reg == 8'h00) ? 9'h100 : {1'b0, lcmp_reg};
      2'h2: per_exp = (ucmp_reg == 8'h00) ? 9'h100 : {1'b0, ucmp_reg};
      2'h3: per_exp = (mode_reg[5:4] == 2'h1) ? 9'h040 :
                      (mode_reg[5:4] == 2'h2) ? 9'h080 : 9'h100;
      default: per_exp = 9'h000;
    endcase
  end
  chk_irq_period: assert property (
    lower_timer_irq_o && seen_reg && per_exp != 9'h000 &&
    mode_reg[1:0] == 2'h1 && !run_reg[2] |-> gap_reg == per_exp)
    else $error("lower irq spacing wrong");
  chk_dual_irq_src: assert property (
    mode_reg[7:6] == 2'h0 && lower_timer_irq_o |-> lower_match_o)
    else $error("dual irq without match");
  chk_casc_no_irq: assert property (
    mode_reg[7:6] == 2'h1 && $past(mode_reg[7:6]) == 2'h1
    |-> !lower_timer_irq_o)
    else $error("lower irq in 16-bit mode");
  chk_casc_both: assert property (
    mode_reg[7:6] == 2'h1 && upper_timer_irq_o |-> lower_match_o)
    else $error("16-bit irq without lower match");
  chk_match_invert: assert property (
    mode_reg[7] && lower_match_o
    |-> $past(timer_output_pin_o, 2) != timer_output_pin_o)
    else $error("match did not invert output");
  chk_ff_clear: assert property (
    wr_en_i && addr_i == `TP_OFF_FFCR &&
    wr_data_i[3:2] == `TP_FF_CTL_CLEAR |=> !timer_output_pin_o)
    else $error("clear command ignored");
  chk_ff_set: assert property (
    wr_en_i && addr_i == `TP_OFF_FFCR &&
    wr_data_i[3:2] == `TP_FF_CTL_SET |=> timer_output_pin_o)
    else $error("set command ignored");
  chk_stop_quiet: assert property (
    $past(run_reg[1:0]) == 2'h0 && $past(run_reg[1:0], 2) == 2'h0
    |-> !lower_match_o && !upper_timer_irq_o)
    else $error("event while stopped");
  chk_unmapped_rd: assert property (
    rd_en_i && addr_i[3] |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
endmodule : timer_pair_properties

bind timer_pair timer_pair_properties chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
  .external_clock_pin_i(external_clock_pin_i),
  .timer_output_pin_o(timer_output_pin_o),
  .lower_timer_irq_o(lower_timer_irq_o),
  .upper_timer_irq_o(upper_timer_irq_o), .lower_match_o(lower_match_o));

// *** timer_prescaler.sv ***
// Free running prescaler giving one-cycle tap enables
`timescale 1ns/100ps
`include "timer_pair_cfg.svh"

module timer_prescaler #(
  parameter int CNT_W = 8
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      prescale_tap_div1_o,
  output logic      prescale_tap_div4_o,
  output logic      prescale_tap_div16_o,
  output logic      prescale_tap_div256_o
);

  logic [CNT_W-1:0] div_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  assign prescale_tap_div1_o = 1'b1;
  assign prescale_tap_div4_o =
    (div_cnt_reg[7:0] & `TP_TAP_DIV4_MASK) == `TP_TAP_DIV4_MASK;
  assign prescale_tap_div16_o =
    (div_cnt_reg[7:0] & `TP_TAP_DIV16_MASK) == `TP_TAP_DIV16_MASK;
  assign prescale_tap_div256_o =
    (div_cnt_reg[7:0] & `TP_TAP_DIV256_MASK) == `TP_TAP_DIV256_MASK;

endmodule : timer_prescaler
